// ===== testbench/epcsr_regs_sva.sv
`timescale 1ns/10ps
// ============================================================
// register bank checker
module epcsr_regs_sva (
   input wire sys_clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   input wire pready,
   input wire [31:0] prdata,
   input wire pslverr,
   input wire [6:0] pcsReset,
   input wire [6:0] loopback
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire wrC0 = psel && penable && pwrite && paddr == 12'h000 && pstrb[1];
   wire rstWr = wrC0 && pwdata[15];
   wire rdSet = psel && !penable && !pwrite;
   a_reset_pulse: assert property (rstWr |=> pcsReset[0] ##1 !pcsReset[0]) else $error("bad reset pulse");
   a_reset_cause: assert property ($rose(pcsReset[0]) |-> $past(rstWr)) else $error("stray reset");
   a_loop_write: assert property (wrC0 |=> loopback[0] == $past(pwdata[14])) else $error("loopback");
   a_loop_hold: assert property (!(psel && penable && pwrite) |=> $stable(loopback)) else $error("loop moved");
   a_ctrl_read: assert property (rdSet && paddr == 12'h000 |=>
      prdata == {16'h0000, 1'b0, loopback[0], 14'h2058}) else $error("control read");
   a_lp_able: assert property (rdSet && paddr == 12'h004 |=> prdata[1] && prdata[31:12] == 20'h0_0000)
      else $error("status read");
   a_ident_zero: assert property (rdSet && (paddr == 12'h008 || paddr == 12'h00C) |=> prdata == 32'h0000_0000)
      else $error("ident read");
   a_pkg_fixed: assert property (rdSet && paddr == 12'h014 |=> prdata == 32'h0000_0008) else $error("pkg");
   a_unmapped_err: assert property (psel && penable && paddr[11] |-> pslverr && pready) else $error("err");
   cover property (rstWr);
   cover property (psel && penable && pslverr);
   cover property (rdSet && paddr == 12'h004);
endmodule
bind epcsr_regs epcsr_regs_sva i_epcsr_regs_sva (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .pcsReset(pcsReset), .loopback(loopback));

// ===== testbench/epcsr_regs_tb_top.sv
`timescale 1ns/10ps
`include "epcsr_defines.vh"
// ============================================================
// register bank testbench
module epcsr_regs_tb_top;
   reg sys_clk = 1'b0;
   reg rst = 1'b1;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0000_0000;
   reg [3:0] pstrb = 4'hF;
   reg [6:0] txIdle = 7'h00, rxIdle = 7'h00, pcsFault = 7'h00, rxLinkUp = 7'h00, highBer = 7'h00, blockLock = 7'h00;
   reg [139:0] laneLock = 140'h0, markerLock = 140'h0;
   reg [31:0] rd;
   wire pready, pslverr;
   wire [31:0] prdata;
   wire [6:0] pcsReset, loopback;
   integer mismatches = 0, cmp_count = 0, i;
   always #5 sys_clk = ~sys_clk;
   epcsr_regs i_epcsr_regs (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .txIdle(txIdle), .rxIdle(rxIdle), .pcsFault(pcsFault), .rxLinkUp(rxLinkUp), .highBer(highBer),
      .blockLock(blockLock), .laneLock(laneLock), .markerLock(markerLock), .pcsReset(pcsReset), .loopback(loopback));
   task stop_test;
      begin
         $display("mismatches %0d compares %0d", mismatches, cmp_count);
         if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task check(input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s, input err);
      integer n;
      begin
         @(posedge sys_clk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         pstrb <= s;
         @(posedge sys_clk);
         penable <= 1'b1;
         @(posedge sys_clk);
         for (n = 0; pready !== 1'b1 && n < 20; n = n + 1) @(posedge sys_clk);
         if (n == 20) begin
            mismatches = mismatches + 1;
            stop_test;
         end
         rd = prdata;
         check(pslverr, err);
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task rdchk(input [11:0] a, input [31:0] e);
      begin
         apb(1'b0, a, 32'h0000_0000, 4'hF, 1'b0);
         check(rd, e);
      end
   endtask
   task settle;
      repeat (6) @(posedge sys_clk);
   endtask
   // ============================================================
   // scenarios
   task t_fixed;
      reg [11:0] b;
      reg [3:0] sp, ty;
      reg [15:0] ab, s2;
      begin
         for (i = 0; i < 7; i = i + 1) begin
            b = {1'b0, i[2:0], 8'h00};
            sp = i < 4 ? `EPCSR_SPD_50G : i < 6 ? `EPCSR_SPD_100G : `EPCSR_SPD_200G;
            ty = i < 4 ? `EPCSR_TYP_50G : i < 6 ? `EPCSR_TYP_100G : `EPCSR_TYP_200G;
            ab = i < 4 ? `EPCSR_ABL_50G : i < 6 ? `EPCSR_ABL_100G : `EPCSR_ABL_200G;
            s2 = i < 4 ? `EPCSR_S2CAP_50G : i < 6 ? `EPCSR_S2CAP_100G : `EPCSR_S2CAP_200G;
            rdchk(b, {18'h0_0000, 8'h81, sp, 2'h0});
            rdchk(b | 12'h004, 32'h0000_0002);
            rdchk(b | 12'h008, 32'h0000_0000);
            rdchk(b | 12'h00C, 32'h0000_0000);
            rdchk(b | 12'h010, {16'h0000, ab});
            rdchk(b | 12'h014, 32'h0000_0008);
            rdchk(b | 12'h018, 32'h0000_0000);
            rdchk(b | 12'h01C, {28'h000_0000, ty});
            rdchk(b | 12'h020, {16'h0000, 16'h8000 | s2});
         end
      end
   endtask
   task t_ctrl;
      begin
         apb(1'b1, 12'h000, 32'h0000_C000, 4'h2, 1'b0);
         #1 check(pcsReset, 32'h0000_0001);
         check(loopback, 32'h0000_0001);
         @(posedge sys_clk);
         #1 check(pcsReset, 32'h0000_0000);
         rdchk(12'h000, 32'h0000_6058);
         apb(1'b1, 12'h000, 32'h0000_0000, 4'h1, 1'b0);
         rdchk(12'h000, 32'h0000_6058);
         apb(1'b1, 12'h000, 32'h0000_0000, 4'hF, 1'b0);
         rdchk(12'h000, 32'h0000_2058);
      end
   endtask
   task t_latch;
      begin
         txIdle[1] <= 1'b1;
         rxIdle[1] <= 1'b1;
         pcsFault[1] <= 1'b1;
         rxLinkUp <= 7'h7F;
         settle;
         rdchk(12'h104, 32'h0000_0F82);
         txIdle[1] <= 1'b0;
         rxIdle[1] <= 1'b0;
         pcsFault[1] <= 1'b0;
         settle;
         rdchk(12'h104, 32'h0000_0C06);
         rdchk(12'h104, 32'h0000_0006);
         rdchk(12'h120, 32'h0000_8981);
         rdchk(12'h120, 32'h0000_8181);
         rxLinkUp[1] <= 1'b0;
         settle;
         rxLinkUp[1] <= 1'b1;
         settle;
         rdchk(12'h104, 32'h0000_0002);
         rdchk(12'h104, 32'h0000_0006);
      end
   endtask
   task t_lanes;
      begin
         highBer[3] <= 1'b1;
         blockLock[3] <= 1'b1;
         laneLock[79:60] <= 20'hA_5C3A;
         markerLock[79:60] <= 20'h5_A3C5;
         settle;
         rdchk(12'h380, 32'h0000_1003);
         rdchk(12'h3C8, 32'h0000_003A);
         rdchk(12'h3CC, 32'h0000_0A5C);
         rdchk(12'h3D0, 32'h0000_00C5);
         rdchk(12'h3D4, 32'h0000_05A3);
         laneLock[79:60] <= 20'hF_FFFF;
         markerLock[79:60] <= 20'hF_FFFF;
         settle;
         rdchk(12'h3C8, 32'h0000_10FF);
         markerLock[60] <= 1'b0;
         settle;
         rdchk(12'h3C8, 32'h0000_00FF);
      end
   endtask
   task t_err;
      begin
         apb(1'b0, 12'h024, 32'h0000_0000, 4'hF, 1'b1);
         check(rd, 32'h0000_0000);
         apb(1'b0, 12'h800, 32'h0000_0000, 4'hF, 1'b1);
         apb(1'b0, 12'h700, 32'h0000_0000, 4'hF, 1'b1);
         apb(1'b1, 12'h01C, 32'hFFFF_FFFF, 4'hF, 1'b0);
         rdchk(12'h01C, 32'h0000_0008);
      end
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      t_fixed;
      t_ctrl;
      t_latch;
      t_lanes;
      t_err;
      stop_test;
   end
endmodule

// ===== verilog/epcsr_defines.vh
`ifndef EPCSR_DEFINES_VH
`define EPCSR_DEFINES_VH
// ============================================================
// register offsets
`define EPCSR_OFS_CTRL1 8'h00
`define EPCSR_OFS_STAT1 8'h04
`define EPCSR_OFS_IDLO 8'h08
`define EPCSR_OFS_IDHI 8'h0C
`define EPCSR_OFS_SPEED 8'h10
`define EPCSR_OFS_PKG1 8'h14
`define EPCSR_OFS_PKG2 8'h18
`define EPCSR_OFS_CTRL2 8'h1C
`define EPCSR_OFS_STAT2 8'h20
`define EPCSR_OFS_BASER 8'h80
`define EPCSR_OFS_LANE_LO 8'hC8
`define EPCSR_OFS_LANE_HI 8'hCC
`define EPCSR_OFS_MARK_LO 8'hD0
`define EPCSR_OFS_MARK_HI 8'hD4
// ============================================================
// instance layout
`define EPCSR_NINST 7
`define EPCSR_INST_200 3'h6
`define EPCSR_INST_01 3'h4
`define EPCSR_INST_23 3'h5
`define EPCSR_NLANE 20
`define EPCSR_LANE_LO_W 8
`define EPCSR_LANE_HI_W 12
// ============================================================
// field positions
`define EPCSR_B_RESET 15
`define EPCSR_B_LOOP 14
`define EPCSR_B_TXLATCH 11
`define EPCSR_B_RXLATCH 10
`define EPCSR_B_TXNOW 9
`define EPCSR_B_RXNOW 8
`define EPCSR_B_FAULT 7
`define EPCSR_B_LINK 2
`define EPCSR_B_LPABLE 1
`define EPCSR_B_S2FAULT 11
`define EPCSR_B_BRLINK 12
`define EPCSR_B_HIBER 1
`define EPCSR_B_BLOCK 0
`define EPCSR_B_ALIGN 12
`define EPCSR_F_SPD_HI 5
`define EPCSR_F_SPD_LO 2
`define EPCSR_F_TYP_HI 3
`define EPCSR_F_HALF_HI 15
// ============================================================
// fixed values
`define EPCSR_CTRL1_RSVD 16'h2040
`define EPCSR_PKG1_VAL 32'h0000_0008
`define EPCSR_ZERO 32'h0000_0000
`define EPCSR_PRESENT 16'h8000
`define EPCSR_SPD_50G 4'h6
`define EPCSR_SPD_100G 4'h4
`define EPCSR_SPD_200G 4'h0
`define EPCSR_TYP_50G 4'h8
`define EPCSR_TYP_100G 4'h5
`define EPCSR_TYP_200G 4'hC
`define EPCSR_ABL_50G 16'h0031
`define EPCSR_ABL_100G 16'h0008
`define EPCSR_ABL_200G 16'h0000
`define EPCSR_S2CAP_50G 16'h0181
`define EPCSR_S2CAP_100G 16'h0020
`define EPCSR_S2CAP_200G 16'h0000
`endif

// ===== verilog/epcsr_regs.v
`timescale 1ns/10ps
`include "epcsr_defines.vh"
module epcsr_regs (
   input wire sys_clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output wire pready,
   output wire [31:0] prdata,
   output wire pslverr,
   input wire [6:0] txIdle,
   input wire [6:0] rxIdle,
   input wire [6:0] pcsFault,
   input wire [6:0] rxLinkUp,
   input wire [6:0] highBer,
   input wire [6:0] blockLock,
   input wire [139:0] laneLock,
   input wire [139:0] markerLock,
   output wire [6:0] pcsReset,
   output wire [6:0] loopback
);
   localparam SW = 322;
   // ============================================================
   // input synchronisers
   reg [SW-1:0] meta_q;
   reg [SW-1:0] sync_q;
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_q <= {SW{1'b0}};
         sync_q <= {SW{1'b0}};
      end else begin
         meta_q <= {markerLock, laneLock, blockLock, highBer, pcsFault, rxLinkUp, rxIdle, txIdle};
         sync_q <= meta_q;
      end
   end
   wire [6:0] sTx = sync_q[6:0];
   wire [6:0] sRx = sync_q[13:7];
   wire [6:0] sLink = sync_q[20:14];
   wire [6:0] sFault = sync_q[27:21];
   wire [6:0] sBer = sync_q[34:28];
   wire [6:0] sBlock = sync_q[41:35];
   wire [139:0] sLane = sync_q[181:42];
   wire [139:0] sMark = sync_q[321:182];

   // ============================================================
   // decoding helpers
   function mapped;
      input [7:0] ofs;
      begin
         case (ofs)
            `EPCSR_OFS_CTRL1, `EPCSR_OFS_STAT1, `EPCSR_OFS_IDLO, `EPCSR_OFS_IDHI,
            `EPCSR_OFS_SPEED, `EPCSR_OFS_PKG1, `EPCSR_OFS_PKG2, `EPCSR_OFS_CTRL2,
            `EPCSR_OFS_STAT2, `EPCSR_OFS_BASER, `EPCSR_OFS_LANE_LO, `EPCSR_OFS_LANE_HI,
            `EPCSR_OFS_MARK_LO, `EPCSR_OFS_MARK_HI: mapped = 1'b1;
            default: mapped = 1'b0;
         endcase
      end
   endfunction

   function [1:0] rateClass;
      input [2:0] inst;
      begin
         if (inst == `EPCSR_INST_200) begin
            rateClass = 2'd2;
         end else if (inst == `EPCSR_INST_01 || inst == `EPCSR_INST_23) begin
            rateClass = 2'd1;
         end else begin
            rateClass = 2'd0;
         end
      end
   endfunction

   // ============================================================
   // apb decode
   wire [2:0] inst = paddr[10:8];
   wire [7:0] ofs = paddr[7:0];
   wire hit = (inst < `EPCSR_NINST) && mapped(ofs) && (paddr[11] == 1'b0);
   wire setup = psel && !penable;
   wire access = psel && penable;
   wire wrHit = access && pwrite && hit;
   wire rdHit = access && !pwrite && hit;
   assign pready = 1'b1;

   // ============================================================
   // control and latched status per instance
   reg [6:0] rst_q;
   reg [6:0] loop_q;
   reg [6:0] txLatch_q;
   reg [6:0] rxLatch_q;
   reg [6:0] downLatch_q;
   reg [6:0] s2Fault_q;
   genvar g;
   generate
      for (g = 0; g < `EPCSR_NINST; g = g + 1) begin : inst_g
         wire sel = (inst == g);
         wire ctrlWr = wrHit && sel && (ofs == `EPCSR_OFS_CTRL1) && pstrb[1];
         wire st1Rd = rdHit && sel && (ofs == `EPCSR_OFS_STAT1);
         wire st2Rd = rdHit && sel && (ofs == `EPCSR_OFS_STAT2);
         always @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               rst_q[g] <= 1'b0;
               loop_q[g] <= 1'b0;
               txLatch_q[g] <= 1'b0;
               rxLatch_q[g] <= 1'b0;
               downLatch_q[g] <= 1'b1;
               s2Fault_q[g] <= 1'b0;
            end else begin
               rst_q[g] <= ctrlWr && pwdata[`EPCSR_B_RESET];
               if (ctrlWr) begin
                  loop_q[g] <= pwdata[`EPCSR_B_LOOP];
               end
               txLatch_q[g] <= sTx[g] || (txLatch_q[g] && !st1Rd);
               rxLatch_q[g] <= sRx[g] || (rxLatch_q[g] && !st1Rd);
               downLatch_q[g] <= !sLink[g] || (downLatch_q[g] && !st1Rd);
               s2Fault_q[g] <= sFault[g] || (s2Fault_q[g] && !st2Rd);
            end
         end
      end
   endgenerate
   assign pcsReset = rst_q;
   assign loopback = loop_q;

   // ============================================================
   // read mux
   reg [31:0] rd;
   reg [3:0] spd;
   reg [3:0] typ;
   reg [15:0] abl;
   reg [15:0] cap;
   reg [19:0] lanes;
   reg [19:0] marks;
   always @* begin
      rd = `EPCSR_ZERO;
      lanes = sLane[inst * `EPCSR_NLANE +: `EPCSR_NLANE];
      marks = sMark[inst * `EPCSR_NLANE +: `EPCSR_NLANE];
      case (rateClass(inst))
         2'd0: begin
            spd = `EPCSR_SPD_50G;
            typ = `EPCSR_TYP_50G;
            abl = `EPCSR_ABL_50G;
            cap = `EPCSR_S2CAP_50G;
         end
         2'd1: begin
            spd = `EPCSR_SPD_100G;
            typ = `EPCSR_TYP_100G;
            abl = `EPCSR_ABL_100G;
            cap = `EPCSR_S2CAP_100G;
         end
         default: begin
            spd = `EPCSR_SPD_200G;
            typ = `EPCSR_TYP_200G;
            abl = `EPCSR_ABL_200G;
            cap = `EPCSR_S2CAP_200G;
         end
      endcase
      if (hit) begin
         case (ofs)
            `EPCSR_OFS_CTRL1: begin
               rd[`EPCSR_F_HALF_HI:0] = `EPCSR_CTRL1_RSVD;
               rd[`EPCSR_B_RESET] = rst_q[inst];
               rd[`EPCSR_B_LOOP] = loop_q[inst];
               rd[`EPCSR_F_SPD_HI:`EPCSR_F_SPD_LO] = spd;
            end
            `EPCSR_OFS_STAT1: begin
               rd[`EPCSR_B_TXLATCH] = txLatch_q[inst];
               rd[`EPCSR_B_RXLATCH] = rxLatch_q[inst];
               rd[`EPCSR_B_TXNOW] = sTx[inst];
               rd[`EPCSR_B_RXNOW] = sRx[inst];
               rd[`EPCSR_B_FAULT] = sFault[inst];
               rd[`EPCSR_B_LINK] = sLink[inst] && !downLatch_q[inst];
               rd[`EPCSR_B_LPABLE] = 1'b1;
            end
            `EPCSR_OFS_IDLO, `EPCSR_OFS_IDHI: rd = `EPCSR_ZERO;
            `EPCSR_OFS_SPEED: rd[`EPCSR_F_HALF_HI:0] = abl;
            `EPCSR_OFS_PKG1: rd = `EPCSR_PKG1_VAL;
            `EPCSR_OFS_PKG2: rd = `EPCSR_ZERO;
            `EPCSR_OFS_CTRL2: rd[`EPCSR_F_TYP_HI:0] = typ;
            `EPCSR_OFS_STAT2: begin
               rd[`EPCSR_F_HALF_HI:0] = `EPCSR_PRESENT | cap;
               rd[`EPCSR_B_S2FAULT] = s2Fault_q[inst];
            end
            `EPCSR_OFS_BASER: begin
               rd[`EPCSR_B_BRLINK] = sLink[inst];
               rd[`EPCSR_B_HIBER] = sBer[inst];
               rd[`EPCSR_B_BLOCK] = sBlock[inst];
            end
            `EPCSR_OFS_LANE_LO: begin
               rd[`EPCSR_LANE_LO_W-1:0] = lanes[`EPCSR_LANE_LO_W-1:0];
               rd[`EPCSR_B_ALIGN] = (&lanes) && (&marks);
            end
            `EPCSR_OFS_LANE_HI: rd[`EPCSR_LANE_HI_W-1:0] = lanes[`EPCSR_NLANE-1:`EPCSR_LANE_LO_W];
            `EPCSR_OFS_MARK_LO: rd[`EPCSR_LANE_LO_W-1:0] = marks[`EPCSR_LANE_LO_W-1:0];
            `EPCSR_OFS_MARK_HI: rd[`EPCSR_LANE_HI_W-1:0] = marks[`EPCSR_NLANE-1:`EPCSR_LANE_LO_W];
            default: rd = `EPCSR_ZERO;
         endcase
      end
   end

   // ============================================================
   // read data and error captured in setup phase
   reg [31:0] rdata_q;
   reg err_q;
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= `EPCSR_ZERO;
         err_q <= 1'b0;
      end else if (setup) begin
         rdata_q <= pwrite ? `EPCSR_ZERO : rd;
         err_q <= !hit;
      end
   end
   assign prdata = rdata_q;
   assign pslverr = access && err_q;
endmodule
